// ---- rtl/byte_selector.sv ----
/*
  One-of-four byte selector producing active-low byte driver enables.
  Assumes sel, read and offset come from synchronised pins.
*/
`timescale 1ns/1ps
module byte_selector (
  decode_if.decoder bus
);

  always_comb begin
    bus.byte_en_n = 4'hF;
    // Only a selected read opens a driver; a write leaves all closed.
    if (bus.sel && bus.read) begin // [R10] [R12]
      bus.byte_en_n = ~(4'h1 << bus.offset); // [R10]
    end
  end

endmodule : byte_selector

// ---- rtl/card_pkg.sv ----
/*
  Constants shared by the sixteen-input status card: address decode layout,
  byte offsets within the card, pin widths and reset values.
  Assumes a host bus with nine low address lines seen by the card.
*/
package card_pkg;

  localparam int STATUS_W = 16;
  localparam int BYTE_W   = 8;
  localparam int ADDR_W   = 9;
  localparam int SLOT_W   = 4;
  localparam int OFS_W    = 2;

  // Address bit positions used by the card select.
  localparam int ADDR_BIT_A6 = 6;
  localparam int ADDR_BIT_A7 = 7;
  localparam int ADDR_BIT_A8 = 8;
  localparam int SLOT_LSB    = 2;

  // Lowest card address (slot zero, offset zero) and the span of one card.
  localparam logic [15:0] CARD_BASE  = 16'h80C0;
  localparam logic [15:0] CARD_SPAN  = 16'h0004;

  // Byte offsets inside the card, taken from address bits 1 and 0.
  localparam logic [1:0] OFS_LOW    = 2'h0;
  localparam logic [1:0] OFS_HIGH   = 2'h1;
  localparam logic [1:0] OFS_ID     = 2'h2;
  localparam logic [1:0] OFS_UNUSED = 2'h3;

  // Reset values.
  localparam logic [15:0] STATUS_IDLE = 16'hFFFF;
  localparam logic [7:0]  DATA_RESET  = 8'h00;

  // Flip-flop stages on every pin input.
  localparam int SYNC_STAGES = 3;

  // Edges from a stable pin change to the bus output following it.
  localparam int READ_LATENCY = 5;

endpackage : card_pkg

// ---- rtl/decode_if.sv ----
/*
  Carrier between the card's address decode and its one-of-four selector.
  Assumes both ends run on the card's single clock.
*/
`timescale 1ns/1ps
interface decode_if;
  logic       sel;
  logic       read;
  logic [1:0] offset;
  logic [3:0] byte_en_n;

  modport card    (output sel, output read, output offset, input byte_en_n);
  modport decoder (input sel, input read, input offset, output byte_en_n);
endinterface : decode_if

// ---- rtl/pin_sync.sv ----
/*
  Three-stage pin synchroniser with agreement filter, one lane per bit.
  Assumes inputs may change at any time relative to clock_i.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] stable_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_lane
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          stage1[b]   <= RESET_VALUE[b];
          stage2[b]   <= RESET_VALUE[b];
          stage3[b]   <= RESET_VALUE[b];
          stable_o[b] <= RESET_VALUE[b];
        end else begin
          stage1[b] <= async_i[b];
          stage2[b] <= stage1[b];
          stage3[b] <= stage2[b];
          // A change is accepted only once two later stages hold it alike.
          if (stage2[b] == stage3[b]) begin
            stable_o[b] <= stage3[b];
          end
        end
      end
      assign agree[b] = ~(stage2[b] ^ stage3[b]);
    end
  endgenerate

  a_filter_agree: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ((stable_o ^ $past(stable_o)) & ~$past(agree)) == '0)
    else $error("filtered pin changed without stage agreement");

endmodule : pin_sync

// ---- rtl/status_input_card.sv ----
/*
  Sixteen-input status card: host address decode, byte selection and the
  registered data bus driver, with word snapshot for coherent 16-bit reads.
  Assumes host bus pins are asynchronous to clock_i and held stable for at
  least card_pkg::READ_LATENCY + 1 cycles around each strobe.
*/
`timescale 1ns/1ps
// Summary of operation
// R1: Sixteen status inputs are readable as single bits or as one sixteen-bit word.
// R2: A status input counts as active, reading one, when its line is low.
// R3: The four-bit position switch selects one of sixteen card positions, 0 to 15.
// R4: Position N carries channels 16N+1 to 16N+16.
// R5: Select needs the strobe, A6 and A7 high, A8 low and the slot bits equal to the switch.
// R6: Each card takes four addresses, 80C0-80C3 at setting 0 up to 80FC-80FF at setting F.
// R7: A selected read with A1 and A0 low drives inputs one to eight.
// R8: A selected read with A1 low and A0 high drives inputs nine to sixteen.
// R9: A selected read with A1 high and A0 low drives the card identification byte.
// R10: Decode enables a one-of-four selector whose three used outputs enable byte drivers.
// R11: The host treats the card as present only if some input reads active at power-up.
// R12: The bus is driven only on selected reads; writes and the fourth address do nothing.
module status_input_card #(
  // Arbitrary identification value, not tied to any real part.
  parameter logic [7:0] CARD_ID = 8'h5A
) (
  input  wire logic                            clock_i,
  input  wire logic                            nrst_i,
  input  wire logic                            io_select_i,
  input  wire logic                            read_i,
  input  wire logic [card_pkg::ADDR_W-1:0]     addr_i,
  input  wire logic [card_pkg::STATUS_W-1:0]   status_n_i,
  input  wire logic [card_pkg::SLOT_W-1:0]     card_position_switch_i,
  output logic      [card_pkg::BYTE_W-1:0]     data_o,
  output logic                                 data_oe_o
);

  localparam int PIN_W = 2 + card_pkg::ADDR_W + card_pkg::SLOT_W + card_pkg::STATUS_W;
  localparam logic [PIN_W-1:0] PIN_RESET = {2'b00, {card_pkg::ADDR_W{1'b0}},
                                            {card_pkg::SLOT_W{1'b0}},
                                            card_pkg::STATUS_IDLE};

  logic                            io_select_s;
  logic                            read_s;
  logic [card_pkg::ADDR_W-1:0]     addr_s;
  logic [card_pkg::SLOT_W-1:0]     slot_s;
  logic [card_pkg::STATUS_W-1:0]   status_n_s;
  logic [card_pkg::STATUS_W-1:0]   status_active;
  logic                            slot_match;
  logic [3:0]                      byte_en_q;
  logic                            low_start;
  logic                            high_end;
  logic [card_pkg::STATUS_W-1:0]   snapshot;
  logic                            snapshot_valid;

  decode_if decode_bus ();

  // Pins from the host bus and the field are all asynchronous here.
  pin_sync #(
    .WIDTH       (PIN_W),
    .RESET_VALUE (PIN_RESET)
  ) u_pin_sync (
    .clock_i  (clock_i),
    .nrst_i   (nrst_i),
    .async_i  ({read_i, io_select_i, addr_i, card_position_switch_i, status_n_i}),
    .stable_o ({read_s, io_select_s, addr_s, slot_s, status_n_s})
  );

  // Low on the line means active, so the byte shows an active input as one.
  assign status_active = ~status_n_s; // [R2]

  // Slot bits compare against the switch, giving sixteen four-byte windows.
  assign slot_match = (addr_s[card_pkg::SLOT_LSB +: card_pkg::SLOT_W] == slot_s); // [R3] [R6]

  assign decode_bus.sel = io_select_s
                        & addr_s[card_pkg::ADDR_BIT_A6]
                        & addr_s[card_pkg::ADDR_BIT_A7]
                        & ~addr_s[card_pkg::ADDR_BIT_A8]
                        & slot_match; // [R5]
  assign decode_bus.read   = read_s; // [R12]
  assign decode_bus.offset = addr_s[card_pkg::OFS_W-1:0];

  byte_selector u_byte_selector (
    .bus (decode_bus.decoder)
  );

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      byte_en_q <= 4'hF;
    end else begin
      byte_en_q <= decode_bus.byte_en_n;
    end
  end

  assign low_start = ~decode_bus.byte_en_n[card_pkg::OFS_LOW] & byte_en_q[card_pkg::OFS_LOW];
  assign high_end  = decode_bus.byte_en_n[card_pkg::OFS_HIGH] & ~byte_en_q[card_pkg::OFS_HIGH];

  // A low-byte read freezes all sixteen inputs so the following high-byte
  // read returns the same instant; without it a word could tear between
  // the two byte reads. A high-byte read alone sees the live inputs.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      snapshot       <= {card_pkg::STATUS_W{1'b0}};
      snapshot_valid <= 1'b0;
    end else if (low_start) begin
      snapshot       <= status_active; // [R1]
      snapshot_valid <= 1'b1;
    end else if (high_end) begin
      snapshot_valid <= 1'b0;
    end
  end

  // Byte drivers: three enables used, the fourth address leaves the bus free.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      data_o <= card_pkg::DATA_RESET;
    end else if (!decode_bus.byte_en_n[card_pkg::OFS_LOW]) begin
      data_o <= low_start ? status_active[7:0] : snapshot[7:0]; // [R7] [R4]
    end else if (!decode_bus.byte_en_n[card_pkg::OFS_HIGH]) begin
      data_o <= snapshot_valid ? snapshot[15:8] : status_active[15:8]; // [R8] [R1]
    end else if (!decode_bus.byte_en_n[card_pkg::OFS_ID]) begin
      data_o <= CARD_ID; // [R9]
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= ~&decode_bus.byte_en_n[2:0]; // [R10] [R12]
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_low_byte_read: assert property ( // [R7]
    low_start |=> data_oe_o && data_o == $past(status_active[7:0]))
    else $error("low byte read did not present inputs one to eight");

  a_high_byte_live: assert property ( // [R8]
    (!decode_bus.byte_en_n[card_pkg::OFS_HIGH] && !snapshot_valid)
      |=> data_oe_o && data_o == ~$past(status_n_s[15:8]))
    else $error("high byte read did not present inputs nine to sixteen");

  a_word_coherent: assert property ( // [R1]
    low_start
      |=> snapshot_valid && snapshot == $past(status_active))
    else $error("low byte read did not freeze all sixteen inputs");

  a_snapshot_pair: assert property ( // [R1]
    (snapshot_valid && !decode_bus.byte_en_n[card_pkg::OFS_HIGH])
      |=> data_o == $past(snapshot[15:8]))
    else $error("high byte after low byte is not from the same snapshot");

  a_id_byte_read: assert property ( // [R9]
    !decode_bus.byte_en_n[card_pkg::OFS_ID] |=> data_oe_o && data_o == CARD_ID)
    else $error("identification byte not presented");

  a_one_of_four: assert property ( // [R10]
    $onehot0(~decode_bus.byte_en_n)
      && (!(decode_bus.sel && decode_bus.read) -> decode_bus.byte_en_n == 4'hF))
    else $error("byte selector enabled more than one driver or without select");

  a_quiet_bus: assert property ( // [R12]
    (!decode_bus.sel || !read_s || decode_bus.offset == card_pkg::OFS_UNUSED)
      |=> !data_oe_o ##1 !data_oe_o || decode_bus.sel)
    else $error("bus driven outside a selected read");

  a_window_read: assert property ( // [R6] [R5]
    (io_select_s && read_s && (addr_s[card_pkg::OFS_W-1:0] != card_pkg::OFS_UNUSED)
      && addr_s == 9'(card_pkg::CARD_BASE[8:0] + {slot_s, 2'b00}
                     + {7'h00, addr_s[card_pkg::OFS_W-1:0]}))
      |=> data_oe_o)
    else $error("read inside the card window was not answered");

  a_other_slot: assert property ( // [R3]
    (addr_s[card_pkg::SLOT_LSB +: card_pkg::SLOT_W] != slot_s) |=> !data_oe_o)
    else $error("card answered an address of another position");

  a_active_low: assert property ( // [R2]
    (low_start && status_n_s[0] == 1'b0) |=> data_o[0] == 1'b1)
    else $error("low input line did not read as active");

  a_write_quiet: assert property ( // [R12]
    (decode_bus.sel && !read_s)
      |=> !data_oe_o)
    else $error("card drove the bus during a write cycle");

  a_write_keeps: assert property ( // [R12]
    (decode_bus.sel && !read_s && byte_en_q == 4'hF)
      |=> $stable(snapshot) && $stable(snapshot_valid))
    else $error("write cycle changed the word snapshot");

  // Each term of the select is checked on its own, so a broken term shows by name.
  a_no_strobe: assert property ( // [R5]
    !io_select_s
      |=> !data_oe_o)
    else $error("card answered without the select strobe");

  a_high_a8: assert property ( // [R5]
    addr_s[card_pkg::ADDR_BIT_A8]
      |=> !data_oe_o)
    else $error("card answered with address bit 8 high");

  a_low_a6: assert property ( // [R5]
    !addr_s[card_pkg::ADDR_BIT_A6]
      |=> !data_oe_o)
    else $error("card answered with address bit 6 low");

  a_low_a7: assert property ( // [R5]
    !addr_s[card_pkg::ADDR_BIT_A7]
      |=> !data_oe_o)
    else $error("card answered with address bit 7 low");

  // Reset is checked with the disable lifted; the default one would hide it.
  a_reset_quiet: assert property (disable iff (1'b0) // [R12]
    !nrst_i
      |=> !data_oe_o && data_o == card_pkg::DATA_RESET
          && byte_en_q == 4'hF && !snapshot_valid)
    else $error("reset did not leave the bus undriven and the snapshot free");

  a_data_holds: assert property ( // [R12]
    (&decode_bus.byte_en_n[2:0])
      |=> $stable(data_o))
    else $error("data byte changed while no byte driver was enabled");

  a_unused_keeps: assert property ( // [R12]
    (decode_bus.sel && read_s && decode_bus.offset == card_pkg::OFS_UNUSED && byte_en_q == 4'hF)
      |=> $stable(snapshot_valid) && $stable(data_o))
    else $error("read of the fourth address changed card state");

  // Channel k of this position sits at bit k-1 of the word, low byte first.
  for (genvar b = 0; b < card_pkg::BYTE_W; b++) begin : g_channel
    a_channel_low: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R4] [R2]
      low_start
        |=> data_o[b] == ~$past(status_n_s[b]))
      else $error("low byte bit does not carry its channel");

    a_channel_high: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R4] [R2]
      (!decode_bus.byte_en_n[card_pkg::OFS_HIGH] && !snapshot_valid)
        |=> data_o[b] == ~$past(status_n_s[card_pkg::BYTE_W + b]))
      else $error("high byte bit does not carry its channel");
  end

  // One lane per switch position: a select may only come from that position's window.
  for (genvar p = 0; p < 16; p++) begin : g_position
    a_position_window: assert property (@(posedge clock_i) disable iff (!nrst_i) // [R3] [R6]
      (decode_bus.sel && slot_s == 4'(p))
        |-> addr_s[card_pkg::ADDR_W-1:card_pkg::OFS_W] == 7'(card_pkg::CARD_BASE[8:2] + p))
      else $error("card selected outside the window of its position");
  end

  a_snapshot_release: assert property ( // [R1]
    (high_end && !low_start)
      |=> !snapshot_valid)
    else $error("snapshot not released after the high byte read");

  a_snapshot_hold: assert property ( // [R1]
    !low_start
      |=> $stable(snapshot))
    else $error("word snapshot changed without a low byte read");

  a_valid_after_low: assert property ( // [R1]
    $rose(snapshot_valid)
      |-> $past(low_start))
    else $error("snapshot became valid without a low byte read");

  a_id_keeps_word: assert property ( // [R9] [R1]
    (!decode_bus.byte_en_n[card_pkg::OFS_ID] && byte_en_q[card_pkg::OFS_HIGH])
      |=> $stable(snapshot_valid))
    else $error("identification read changed the word snapshot");

  a_low_stands: assert property ( // [R7]
    (!decode_bus.byte_en_n[card_pkg::OFS_LOW] && !byte_en_q[card_pkg::OFS_LOW])
      |=> $stable(data_o))
    else $error("low byte changed during one read");

  a_high_stands: assert property ( // [R8]
    (!decode_bus.byte_en_n[card_pkg::OFS_HIGH] && !byte_en_q[card_pkg::OFS_HIGH]
      && snapshot_valid)
      |=> $stable(data_o))
    else $error("paired high byte changed during one read");

  // Pin-level latency: three synchroniser stages, the agreement filter register and the output register.
  // It relies on the host holding address and direction before the strobe.
  localparam int ANSWER_MIN = card_pkg::READ_LATENCY - 1;
  localparam int ANSWER_MAX = card_pkg::READ_LATENCY + 1;

  a_answer_latency: assert property ( // [R5] [R6]
    ($rose(io_select_i) && read_i && addr_i[card_pkg::OFS_W-1:0] != card_pkg::OFS_UNUSED
      && addr_i == 9'(card_pkg::CARD_BASE[8:0] + {card_position_switch_i, 2'b00}
                      + {7'h00, addr_i[card_pkg::OFS_W-1:0]}))
      |-> ##[ANSWER_MIN:ANSWER_MAX] data_oe_o)
    else $error("read of the card window not answered in time");

  a_release_latency: assert property ( // [R12]
    $fell(io_select_i)
      |-> ##[ANSWER_MIN:ANSWER_MAX] !data_oe_o)
    else $error("bus still driven after the strobe was removed");

  c_low_read:    cover property (low_start ##1 data_oe_o);
  c_word_read:   cover property (low_start ##[1:20] !decode_bus.byte_en_n[card_pkg::OFS_HIGH]);
  c_id_read:     cover property (!decode_bus.byte_en_n[card_pkg::OFS_ID] ##1 data_oe_o);
  c_unused_read: cover property (decode_bus.sel && read_s
                                 && decode_bus.offset == card_pkg::OFS_UNUSED);
  c_write_cycle: cover property (decode_bus.sel && !read_s);

endmodule : status_input_card

// ---- sim/host_model.sv ----
/*
  Host bus master model: runs read and write cycles on the card's pins.
  Assumes one clock and the pin hold times of the card's bus contract.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       clock_i,
  output logic            io_select_o,
  output logic            read_o,
  output logic [8:0]      addr_o,
  input  wire logic [7:0] data_i,
  input  wire logic       data_oe_i
);
  initial begin
    io_select_o = 1'b0;
    read_o      = 1'b0;
    addr_o      = 9'h000;
  end

  // Address and direction lead the strobe by six cycles because the card resamples its pins.
  task automatic access(input logic [8:0] a, input logic rd, output logic [7:0] d,
                        output logic drv);
    int n;
    drv = 1'b0;
    d   = 8'h00;
    @(posedge clock_i);
    #1;
    addr_o = a;
    read_o = rd;
    repeat (6) @(posedge clock_i);
    #1 io_select_o = 1'b1;
    for (n = 0; n < 8 && !drv; n++) begin
      @(posedge clock_i);
      #1;
      if (data_oe_i === 1'b1) begin
        d   = data_i;
        drv = 1'b1;
      end
    end
    io_select_o = 1'b0;
    for (n = 0; n < 8 && data_oe_i !== 1'b0; n++) @(posedge clock_i);
    repeat (6) @(posedge clock_i);
    // Idle lines show a changed value so a stale address can never pass for a held one.
    #1 addr_o = ~a;
    read_o = ~rd;
  endtask : access

  task automatic probe_present(input logic [8:0] base, output logic present);
    logic [7:0] lo, hi;
    logic       dl, dh;
    access(base, 1'b1, lo, dl);
    access(base | 9'h001, 1'b1, hi, dh);
    present = dl && dh && ((lo | hi) != 8'h00);
  endtask : probe_present
endmodule : host_model

// ---- sim/test_sixteen_bit_status_input_port.sv ----
/*
  Self-checking bench for the status card: a host model reads it through its
  pins while the bench sets the position switch and the status lines.
*/
`timescale 1ns/1ps
module test_sixteen_bit_status_input_port;
  // Arbitrary identification byte for this bench.
  localparam logic [7:0] ID_VAL = 8'h3C;
  logic        clock_i     = 1'b0;
  logic        nrst_i      = 1'b0;
  logic        io_select;
  logic        read;
  logic [8:0]  addr;
  logic [15:0] status_n    = 16'hFFFF;
  logic [3:0]  slot        = 4'h0;
  logic [7:0]  data;
  logic        data_oe;
  logic        present;
  int          n_mismatch  = 0;
  int          checks_done = 0;

  always #5 clock_i = ~clock_i;

  status_input_card #(.CARD_ID(ID_VAL)) u_status_input_card (
    .clock_i(clock_i), .nrst_i(nrst_i), .io_select_i(io_select), .read_i(read),
    .addr_i(addr), .status_n_i(status_n), .card_position_switch_i(slot),
    .data_o(data), .data_oe_o(data_oe));

  host_model u_host_model (
    .clock_i(clock_i), .io_select_o(io_select), .read_o(read), .addr_o(addr),
    .data_i(data), .data_oe_i(data_oe));

  function automatic logic [8:0] card_addr(input logic [3:0] s, input logic [1:0] ofs);
    logic [15:0] a;
    a = card_pkg::CARD_BASE + 16'(s) * card_pkg::CARD_SPAN + 16'(ofs);
    return a[8:0];
  endfunction : card_addr

  task automatic compare(input logic [8:0] got, input logic [8:0] want);
    checks_done++;
    if (got !== want) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, want);
    end
  endtask : compare

  task automatic rd_check(input logic [8:0] a, input logic rd, input logic [8:0] want);
    logic [7:0] d;
    logic       drv;
    u_host_model.access(a, rd, d, drv);
    compare({drv, drv ? d : 8'h00}, want);
  endtask : rd_check

  task automatic set_inputs(input logic [3:0] s, input logic [15:0] active);
    @(posedge clock_i);
    #1 slot = s;
    status_n = ~active;
  endtask : set_inputs

  task automatic t_positions();
    for (int s = 0; s < 16; s++) begin
      set_inputs(4'(s), 16'h00A5 ^ 16'(s));
      rd_check(card_addr(4'(s), 2'h0), 1'b1, {1'b1, 8'hA5 ^ 8'(s)});
      rd_check(card_addr(4'(s) ^ 4'h1, 2'h0), 1'b1, 9'h000);
    end
  endtask : t_positions

  task automatic t_bytes();
    set_inputs(4'h9, 16'hC35A);
    rd_check(card_addr(4'h9, card_pkg::OFS_LOW), 1'b1, 9'h15A);
    rd_check(card_addr(4'h9, card_pkg::OFS_HIGH), 1'b1, 9'h1C3);
    rd_check(card_addr(4'h9, card_pkg::OFS_ID), 1'b1, {1'b1, ID_VAL});
    rd_check(card_addr(4'h9, card_pkg::OFS_UNUSED), 1'b1, 9'h000);
    rd_check(card_addr(4'h9, card_pkg::OFS_LOW), 1'b0, 9'h000);
    rd_check(card_addr(4'h9, card_pkg::OFS_LOW), 1'b1, 9'h15A);
  endtask : t_bytes

  task automatic t_refuse();
    set_inputs(4'h3, 16'h00FF);
    rd_check(card_addr(4'h3, 2'h0) | 9'h100, 1'b1, 9'h000);
    rd_check(card_addr(4'h3, 2'h0) & ~9'h040, 1'b1, 9'h000);
    rd_check(card_addr(4'h3, 2'h0) & ~9'h080, 1'b1, 9'h000);
  endtask : t_refuse

  // A word read is low byte first; the high byte must come from the same instant.
  task automatic t_word();
    set_inputs(4'hF, 16'h1234);
    rd_check(card_addr(4'hF, 2'h0), 1'b1, 9'h134);
    set_inputs(4'hF, 16'hABCD);
    rd_check(card_addr(4'hF, 2'h1), 1'b1, 9'h112);
    rd_check(card_addr(4'hF, 2'h1), 1'b1, 9'h1AB);
    rd_check(card_addr(4'hF, 2'h0), 1'b1, 9'h1CD);
  endtask : t_word

  task automatic t_presence();
    set_inputs(4'h2, 16'h0000);
    u_host_model.probe_present(card_addr(4'h2, 2'h0), present);
    compare({8'h00, present}, 9'h000);
    set_inputs(4'h2, 16'h8000);
    u_host_model.probe_present(card_addr(4'h2, 2'h0), present);
    compare({8'h00, present}, 9'h001);
  endtask : t_presence

  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    t_positions();
    t_bytes();
    t_refuse();
    t_word();
    t_presence();
    conclude();
  end
endmodule : test_sixteen_bit_status_input_port
